/* rbs_reset_boot_mux.sv */
`timescale 1ns/1ps
// Function
// RL1: Wait 4096 input clocks after reset, then run.
// RL2: Board holds reset low during power-up.
// RL3: Boot straps stable before reset asserts.
// RL4: Decode boot straps: slave, master, parallel, reserved.
// RL5: Start-up core clock from sampled ratio straps.
// RL6: Ratio codes give 6, 32, 16; 11 reserved.
// RL7: Software ratio override once out of reset.
// RL8: Bit 12 picks PLL clock or reset-out.
// RL9: Board pulses or holds test clock low.
// RL10: Board pulses or holds test reset low.
// RL11: Input clock runs steady at legal rate.
// RL12: Mode field muxes data pins between functions.
// RL13: Modes 000-011 memory, split, all flags.
// RL14: Modes 100, 101 low byte; 111 three-states.
// RL15: Reset-out held until execution begins.
module rbs_reset_boot_mux
    import rbs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = RBS_LOCK_CYCLES
)(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        proc_reset_n,
    input  wire logic [1:0]  boot_mode_strap_bits,
    input  wire logic [1:0]  clock_ratio_strap_bits,
    input  wire logic        pll_clk_in,
    output logic             clock_or_reset_out,
    output logic             core_run,
    output logic             core_reset_n,
    output rbs_boot_t        boot_mode,
    output logic [5:0]       core_mult,
    output logic [1:0]       core_div,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic [15:0] data_pin_in,
    output logic [15:0]      data_pin_out,
    output logic [15:0]      data_pin_oe,
    input  wire logic [15:0] mem_data_out,
    input  wire logic        mem_data_oe,
    output logic [15:0]      mem_data_in,
    input  wire logic [15:0] flag_out,
    input  wire logic [15:0] flag_oe,
    output logic [15:0]      flag_in,
    output logic [15:0]      parallel_acquisition_port_data_in
);

    // Lock counter is 16 bits wide, so longer waits cannot be counted
    if (LOCK_CYCLES < 2 || LOCK_CYCLES > 65536)
    begin : g_bad_lock
        $error("LOCK_CYCLES out of range");
    end

    rbs_state_t  state;
    rbs_state_t  next_state;
    logic [15:0] lock_cnt;
    rbs_strap_t  strap_q;
    rbs_pm_t     pm_reg;
    rbs_sys_t    sys_reg;
    logic        override;

    // Device reset pin and register bus reset together
    wire logic       dev_rst   = sys_rst | ~proc_reset_n;
    wire logic       lock_done = (lock_cnt == 16'(LOCK_CYCLES - 1));
    wire logic       pm_wr     = reg_wr && (reg_addr == RBS_ADDR_PM);
    wire logic       sys_wr    = reg_wr && (reg_addr == RBS_ADDR_SYS);
    wire logic       running   = (state == RBS_ST_RUN);
    wire logic       rst_out_n = running; // RL15
    wire logic [2:0] pin_mode  = sys_reg.pin_mode;

    // Sequencer: held in reset, lock wait, then run
    always_comb
    begin
        next_state = state;
        unique case (state)
            RBS_ST_RESET: next_state = RBS_ST_LOCK;
            RBS_ST_LOCK:  if (lock_done) next_state = RBS_ST_RUN; // RL1
            RBS_ST_RUN:   next_state = RBS_ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            state    <= RBS_ST_RESET;
            lock_cnt <= '0;
        end
        else
        begin
            state    <= next_state;
            lock_cnt <= (state == RBS_ST_LOCK) ? lock_cnt + 16'h0001 : '0; // RL1
        end
    end

    // Straps track the pins while reset is low, freeze at release
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            strap_q <= '0;
        else if (!proc_reset_n)
            strap_q <= {boot_mode_strap_bits, clock_ratio_strap_bits}; // RL3 RL5
    end

    // Writes to power management only count once the core runs
    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            pm_reg   <= RBS_PM_RESET;
            sys_reg  <= RBS_SYS_RESET;
            override <= 1'b0;
        end
        else
        begin
            if (pm_wr && running)
            begin
                pm_reg   <= reg_wdata; // RL7
                override <= 1'b1;
            end
            if (sys_wr)
                sys_reg <= reg_wdata; // RL12
        end
    end

    // Strap decodes
    logic [5:0] strap_mult;
    rbs_boot_t  strap_boot;
    always_comb
    begin
        unique case (strap_q.ratio)
            RBS_CODE_00: strap_mult = RBS_RATIO_6; // RL6
            RBS_CODE_01: strap_mult = RBS_RATIO_32;
            RBS_CODE_10: strap_mult = RBS_RATIO_16;
            RBS_CODE_11: strap_mult = RBS_RATIO_6; // Reserved: safest low rate
        endcase
        unique case (strap_q.boot)
            RBS_CODE_00: strap_boot = RBS_BOOT_SPI_SLAVE; // RL4
            RBS_CODE_01: strap_boot = RBS_BOOT_SPI_MASTER;
            RBS_CODE_10: strap_boot = RBS_BOOT_PARALLEL;
            RBS_CODE_11: strap_boot = RBS_BOOT_RSVD;
        endcase
    end

    wire logic [5:0] next_mult = override ? pm_reg.mult : strap_mult; // RL5 RL7
    wire logic [1:0] next_div  = override ? pm_reg.div : RBS_DIV_ONE;
    wire logic       next_clk  = pm_reg.clk_sel ? pll_clk_in : rst_out_n; // RL8

    // Clock configuration and pin outputs come from flops
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            core_mult          <= RBS_RATIO_6;
            core_div           <= RBS_DIV_ONE;
            boot_mode          <= RBS_BOOT_SPI_SLAVE;
            clock_or_reset_out <= 1'b0;
        end
        else
        begin
            core_mult          <= next_mult;
            core_div           <= next_div;
            boot_mode          <= strap_boot;
            clock_or_reset_out <= next_clk; // RL8 RL15
        end
    end

    assign core_run     = running; // RL1
    assign core_reset_n = rst_out_n;

    // Byte ownership per mode; upper byte goes to the acquisition port in 100/101
    rbs_own_t own_hi;
    rbs_own_t own_lo;
    always_comb
    begin
        unique case (pin_mode)
            RBS_PIN_MEM_A, RBS_PIN_MEM_B:
            begin
                own_hi = RBS_OWN_MEM; // RL13
                own_lo = RBS_OWN_MEM;
            end
            RBS_PIN_FLAG_HI:
            begin
                own_hi = RBS_OWN_FLAG; // RL13
                own_lo = RBS_OWN_MEM;
            end
            RBS_PIN_FLAG_ALL:
            begin
                own_hi = RBS_OWN_FLAG; // RL13
                own_lo = RBS_OWN_FLAG;
            end
            RBS_PIN_MEM_LO:
            begin
                own_hi = RBS_OWN_PARALLEL_ACQUISITION_PORT; // RL14
                own_lo = RBS_OWN_MEM;
            end
            RBS_PIN_FLAG_LO:
            begin
                own_hi = RBS_OWN_PARALLEL_ACQUISITION_PORT; // RL14
                own_lo = RBS_OWN_FLAG;
            end
            RBS_PIN_RSVD, RBS_PIN_TRI:
            begin
                own_hi = RBS_OWN_NONE; // RL14
                own_lo = RBS_OWN_NONE;
            end
        endcase
    end

    // One pin mux per byte; the acquisition port is input only
    genvar gb;
    generate
        for (gb = 0; gb < 2; gb++)
        begin : g_byte
            rbs_own_t   own;
            logic [7:0] nxt_out;
            logic [7:0] nxt_oe;
            logic [7:0] out_q, oe_q, mem_q, flag_q, parallel_acquisition_port_q;
            assign own = (gb == 1) ? own_hi : own_lo;
            assign nxt_out = (own == RBS_OWN_MEM)  ? mem_data_out[gb*8 +: 8] :
                             (own == RBS_OWN_FLAG) ? flag_out[gb*8 +: 8] : 8'h00; // RL12
            assign nxt_oe  = (own == RBS_OWN_MEM)  ? {8{mem_data_oe}} :
                             (own == RBS_OWN_FLAG) ? flag_oe[gb*8 +: 8] : 8'h00;
            always_ff @(posedge ref_clk)
            begin
                if (dev_rst)
                begin
                    out_q  <= 8'h00;
                    oe_q   <= 8'h00;
                    mem_q  <= 8'h00;
                    flag_q <= 8'h00;
                    parallel_acquisition_port_q <= 8'h00;
                end
                else
                begin
                    out_q  <= nxt_out;
                    oe_q   <= nxt_oe;
                    mem_q  <= (own == RBS_OWN_MEM)  ? data_pin_in[gb*8 +: 8] : 8'h00;
                    flag_q <= (own == RBS_OWN_FLAG) ? data_pin_in[gb*8 +: 8] : 8'h00;
                    parallel_acquisition_port_q <= (own == RBS_OWN_PARALLEL_ACQUISITION_PORT) ? data_pin_in[gb*8 +: 8] : 8'h00;
                end
            end
            assign data_pin_out[gb*8 +: 8] = out_q; // One driver per byte slice
            assign data_pin_oe[gb*8 +: 8]  = oe_q;
            assign mem_data_in[gb*8 +: 8]  = mem_q;
            assign flag_in[gb*8 +: 8]      = flag_q;
            assign parallel_acquisition_port_data_in[gb*8 +: 8] = parallel_acquisition_port_q;
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    rbs_stat_t stat;
    assign stat = '{rsvd: '0, strap_rsvd: (strap_q.boot == RBS_CODE_11) ||
                    (strap_q.ratio == RBS_CODE_11), ratio: strap_q.ratio,
                    boot: strap_q.boot, override: override, run: running};
    wire logic [31:0] rd_mux = (reg_addr == RBS_ADDR_PM)   ? pm_reg :
                               (reg_addr == RBS_ADDR_SYS)  ? sys_reg :
                               (reg_addr == RBS_ADDR_STAT) ? stat : 32'h0000_0000;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (dev_rst);

    chk_lock_length: assert property ($rose(core_run) |-> // RL1
        $past(lock_cnt) == 16'(LOCK_CYCLES - 1))
        else $error("core started before lock wait ended");
    chk_lock_no_early: assert property ((state == RBS_ST_LOCK && !lock_done) |=> !core_run) // RL1
        else $error("core ran during lock wait");
    chk_boot_decode: assert property (##1 boot_mode == rbs_boot_t'($past(strap_q.boot))) // RL4
        else $error("boot mode decode wrong");
    chk_ratio_map: assert property (!override ##1 !override |-> core_mult ==
        (($past(strap_q.ratio) == RBS_CODE_01) ? RBS_RATIO_32 :
         ($past(strap_q.ratio) == RBS_CODE_10) ? RBS_RATIO_16 : RBS_RATIO_6)) // RL5 RL6
        else $error("strap ratio wrong");
    chk_pm_override: assert property ((pm_wr && running) |=> override ##1 core_mult ==
        $past(reg_wdata[5:0], 2)) // RL7
        else $error("software ratio not applied");
    chk_pm_locked: assert property ((pm_wr && !running) |=> $stable(pm_reg) && !override) // RL7
        else $error("ratio changed before core ran");
    chk_clk_select: assert property (##1 clock_or_reset_out ==
        ($past(pm_reg.clk_sel) ? $past(pll_clk_in) : $past(running))) // RL8
        else $error("clock pin select wrong");
    chk_rstout_hold: assert property ((state == RBS_ST_LOCK && !pm_reg.clk_sel) |=>
        !clock_or_reset_out) // RL15
        else $error("reset-out released early");
    chk_flag_all: assert property ((pin_mode == RBS_PIN_FLAG_ALL) |=>
        data_pin_out == $past(flag_out) && data_pin_oe == $past(flag_oe)) // RL13
        else $error("flag mode routing wrong");
    chk_tri_all: assert property ((pin_mode == RBS_PIN_TRI) |=> data_pin_oe == 16'h0000) // RL14
        else $error("pins driven in three-state mode");

endmodule : rbs_reset_boot_mux

/* rbs_pkg.sv */
package rbs_pkg;

    // Start-up lock wait, counted in input-clock cycles
    localparam int unsigned RBS_LOCK_CYCLES = 4096;

    // Register word addresses on the plain register port
    localparam logic [7:0] RBS_ADDR_PM   = 8'h00;
    localparam logic [7:0] RBS_ADDR_SYS  = 8'h04;
    localparam logic [7:0] RBS_ADDR_STAT = 8'h08;

    // Power-management control: clock pin select sits in bit 12
    typedef struct packed {
        logic [18:0] rsvd_hi;
        logic        clk_sel;
        logic [3:0]  rsvd_lo;
        logic [1:0]  div;
        logic [5:0]  mult;
    } rbs_pm_t;
    localparam logic [31:0] RBS_PM_RESET = 32'h0000_0000;

    // System control: data pin mode field
    typedef struct packed {
        logic [28:0] rsvd;
        logic [2:0]  pin_mode;
    } rbs_sys_t;
    localparam logic [31:0] RBS_SYS_RESET = 32'h0000_0000;

    // Read-only status word
    typedef struct packed {
        logic [24:0] rsvd;
        logic        strap_rsvd;
        logic [1:0]  ratio;
        logic [1:0]  boot;
        logic        override;
        logic        run;
    } rbs_stat_t;

    // Strap levels captured while the device reset pin is low
    typedef struct packed {
        logic [1:0] boot;
        logic [1:0] ratio;
    } rbs_strap_t;

    // Strap codes
    localparam logic [1:0] RBS_CODE_00 = 2'h0;
    localparam logic [1:0] RBS_CODE_01 = 2'h1;
    localparam logic [1:0] RBS_CODE_10 = 2'h2;
    localparam logic [1:0] RBS_CODE_11 = 2'h3;

    // Core to input clock ratios per strap code
    localparam logic [5:0] RBS_RATIO_6  = 6'h06;
    localparam logic [5:0] RBS_RATIO_32 = 6'h20;
    localparam logic [5:0] RBS_RATIO_16 = 6'h10;
    localparam logic [1:0] RBS_DIV_ONE  = 2'h0;

    // Data pin modes
    localparam logic [2:0] RBS_PIN_MEM_A   = 3'h0;
    localparam logic [2:0] RBS_PIN_MEM_B   = 3'h1;
    localparam logic [2:0] RBS_PIN_FLAG_HI = 3'h2;
    localparam logic [2:0] RBS_PIN_FLAG_ALL = 3'h3;
    localparam logic [2:0] RBS_PIN_MEM_LO  = 3'h4;
    localparam logic [2:0] RBS_PIN_FLAG_LO = 3'h5;
    localparam logic [2:0] RBS_PIN_RSVD    = 3'h6;
    localparam logic [2:0] RBS_PIN_TRI     = 3'h7;

    typedef enum logic [1:0] {
        RBS_BOOT_SPI_SLAVE,
        RBS_BOOT_SPI_MASTER,
        RBS_BOOT_PARALLEL,
        RBS_BOOT_RSVD
    } rbs_boot_t;

    typedef enum logic [1:0] {
        RBS_OWN_MEM,
        RBS_OWN_FLAG,
        RBS_OWN_PARALLEL_ACQUISITION_PORT,
        RBS_OWN_NONE
    } rbs_own_t;

    typedef enum logic [1:0] {
        RBS_ST_RESET,
        RBS_ST_LOCK,
        RBS_ST_RUN
    } rbs_state_t;

endpackage : rbs_pkg

/* rbs_board_model.sv */
`timescale 1ns/1ps
// Board side: reset source, strap levels, PLL clock level, test port pins
module rbs_board_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_req,
    input  wire logic [1:0] boot_req,
    input  wire logic [1:0] ratio_req,
    output logic            proc_reset_n,
    output logic [1:0]      boot_mode_strap_bits,
    output logic [1:0]      clock_ratio_strap_bits,
    output logic            pll_clk_in,
    output logic            test_clk,
    output logic            test_rst_n
);
    logic rst_q;
    // Reset pin low from power-up on
    initial
    begin
        {rst_q, proc_reset_n, pll_clk_in} = 3'b100;
        {boot_mode_strap_bits, clock_ratio_strap_bits} = 4'h0;
    end
    // Straps settle one cycle before the reset pin falls
    always @(posedge ref_clk)
    begin
        rst_q        <= rst_req;
        proc_reset_n <= ~rst_q;
        pll_clk_in   <= ~pll_clk_in;
        if (rst_req)
            {boot_mode_strap_bits, clock_ratio_strap_bits} <= {boot_req, ratio_req};
        else if (proc_reset_n)
            // Straps wander after release, so stale captures show up
            {boot_mode_strap_bits, clock_ratio_strap_bits} <=
                ~{boot_mode_strap_bits, clock_ratio_strap_bits};
    end
    // Test port clock and reset held low throughout
    assign test_clk   = 1'b0;
    assign test_rst_n = 1'b0;
endmodule : rbs_board_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import rbs_pkg::*;
;
    localparam int LOCK = 8;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, mem_data_oe, rst_req;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, m_pm, m_sys, exp_rd;
    logic [15:0] data_pin_in, mem_data_out, flag_out, flag_oe;
    logic [15:0] data_pin_out, data_pin_oe, mem_data_in, flag_in, parallel_acquisition_port_data_in;
    logic [1:0]  boot_req, ratio_req, bsb, crsb, core_div, sb, sr;
    logic        proc_reset_n, pll_clk_in, cro, core_run, core_reset_n;
    logic        m_ovr, m_run, waslow, p_sel, p_run, exp_cro, c_rst, inrst;
    logic [5:0]  core_mult;
    logic [2:0]  p_mode;
    logic [79:0] exp_pin;
    rbs_boot_t   boot_mode;
    int          mismatches, checked, cnt;

    rbs_reset_boot_mux #(.LOCK_CYCLES(LOCK)) rbs_reset_boot_mux_i (
        .ref_clk, .sys_rst, .proc_reset_n, .boot_mode_strap_bits(bsb),
        .clock_ratio_strap_bits(crsb), .pll_clk_in, .clock_or_reset_out(cro), .core_run,
        .core_reset_n, .boot_mode, .core_mult, .core_div, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .data_pin_in, .data_pin_out, .data_pin_oe, .mem_data_out,
        .mem_data_oe, .mem_data_in, .flag_out, .flag_oe, .flag_in, .parallel_acquisition_port_data_in);

    rbs_board_model rbs_board_model_i (
        .ref_clk, .rst_req, .boot_req, .ratio_req, .proc_reset_n,
        .boot_mode_strap_bits(bsb), .clock_ratio_strap_bits(crsb), .pll_clk_in,
        .test_clk(), .test_rst_n());

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic cmp_reg(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_reg

    task automatic cmp_pin(input logic [15:0] a, input logic [15:0] e);
        checked++;
        if (a !== e)
        begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : cmp_pin

    task automatic wrap_up;
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // One register port cycle; strobes stay until the next call
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask : bus

    task automatic rnd_in;
        data_pin_in  <= 16'($urandom);
        mem_data_out <= 16'($urandom);
        flag_out     <= 16'($urandom);
        flag_oe      <= 16'($urandom);
        mem_data_oe  <= 1'($urandom);
    endtask : rnd_in

    function automatic logic [5:0] ratio(input logic [1:0] c);
        return c == 2'h1 ? RBS_RATIO_32 : c == 2'h2 ? RBS_RATIO_16 : RBS_RATIO_6;
    endfunction : ratio

    function automatic logic [31:0] rd_model(input logic [7:0] a);
        case (a)
            RBS_ADDR_PM:   return m_pm;
            RBS_ADDR_SYS:  return m_sys;
            RBS_ADDR_STAT: return {25'h0, (sb == 2'h3 || sr == 2'h3), sr, sb, m_ovr, m_run};
            default:       return 32'h0;
        endcase
    endfunction : rd_model

    // Pin owner per mode; out is masked by its enable since undriven bits are free
    function automatic logic [79:0] pins(input logic [2:0] m, input logic [15:0] pin,
            input logic [15:0] mo, input logic moe, input logic [15:0] fo, input logic [15:0] foe);
        logic [15:0] o, e, mi, fi, pd;
        {o, e, mi, fi} = '0;
        pd = (m == 3'h4 || m == 3'h5) ? {pin[15:8], 8'h00} : 16'h0;
        case (m)
            3'h0, 3'h1: {o, e, mi} = {mo, {16{moe}}, pin};
            3'h2: {o, e, mi, fi} = {fo[15:8], mo[7:0], foe[15:8], {8{moe}}, 8'h00, pin[7:0],
                pin[15:8], 8'h00};
            3'h3: {o, e, fi} = {fo, foe, pin};
            3'h4: {o, e, mi} = {8'h00, mo[7:0], 8'h00, {8{moe}}, 8'h00, pin[7:0]};
            3'h5: {o, e, fi} = {8'h00, fo[7:0], 8'h00, foe[7:0], 8'h00, pin[7:0]};
            default: o = 16'h0;
        endcase
        return {o & e, e, mi, fi, pd};
    endfunction : pins

    // Reference model: advance on the edge, compare once the edge has settled
    always @(posedge ref_clk)
    begin
        c_rst   = sys_rst;
        inrst   = sys_rst | ~proc_reset_n;
        exp_pin = pins(p_mode, data_pin_in, mem_data_out, mem_data_oe, flag_out, flag_oe);
        exp_cro = p_sel ? pll_clk_in : p_run;
        exp_rd  = reg_rd ? rd_model(reg_addr) : 32'h0;
        if (!proc_reset_n)
            {sb, sr} = {bsb, crsb};
        if (inrst)
            {m_pm, m_sys, m_ovr} = '0;
        else if (reg_wr && reg_addr == RBS_ADDR_SYS)
            m_sys = reg_wdata;
        else if (reg_wr && reg_addr == RBS_ADDR_PM && m_run)
            {m_pm, m_ovr} = {reg_wdata, 1'b1};
        if (inrst)
            cnt = 0;
        else if (!waslow && cnt <= LOCK)
            cnt++;
        waslow = inrst;
        m_run  = !waslow && cnt >= LOCK;
        #1;
        if (!c_rst)
        begin
            cmp_reg({31'h0, core_run}, {31'h0, m_run});
            cmp_reg({31'h0, core_reset_n}, {31'h0, m_run});
            cmp_reg({31'h0, cro}, {31'h0, exp_cro});
            cmp_reg(reg_rdata, exp_rd);
        end
        if (!inrst)
        begin
            cmp_pin(data_pin_oe, exp_pin[63:48]);
            cmp_pin(data_pin_out & data_pin_oe, exp_pin[79:64]);
            cmp_pin(mem_data_in, exp_pin[47:32]);
            cmp_pin(flag_in, exp_pin[31:16]);
            cmp_pin(parallel_acquisition_port_data_in, exp_pin[15:0]);
        end
        {p_sel, p_run, p_mode} = {m_pm[12], m_run, m_sys[2:0]};
    end

    // Start-up with given straps, refused early write, then a ratio override
    task automatic do_boot(input logic [1:0] c);
        int n;
        {rst_req, boot_req, ratio_req} <= {1'b1, c, c};
        repeat (4) @(posedge ref_clk);
        rst_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus(1'b1, 1'b0, RBS_ADDR_PM, 32'h0000_10ff);
        bus(1'b0, 1'b1, RBS_ADDR_PM, 32'h0);
        bus(1'b0, 1'b1, RBS_ADDR_STAT, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        n = 0;
        while (m_run !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk);
            #2;
            n++;
        end
        if (n == 40)
        begin
            mismatches++;
            wrap_up();
        end
        cmp_reg({30'h0, boot_mode}, {30'h0, c});
        cmp_reg({26'h0, core_mult}, {26'h0, ratio(c)});
        cmp_reg({30'h0, core_div}, {30'h0, RBS_DIV_ONE});
        @(posedge ref_clk);
        bus(1'b0, 1'b1, RBS_ADDR_STAT, 32'h0);
        bus(1'b0, 1'b1, RBS_ADDR_SYS, 32'h0);
        bus(1'b1, 1'b0, RBS_ADDR_PM, {19'h0, 1'b1, 4'h0, 2'h1, 6'h0a});
        bus(1'b0, 1'b1, RBS_ADDR_PM, 32'h0);
        repeat (4) bus(1'b0, 1'b0, 8'h00, 32'h0);
        #2;
        cmp_reg({26'h0, core_mult}, 32'h0a);
        cmp_reg({30'h0, core_div}, 32'h1);
        @(posedge ref_clk);
        bus(1'b1, 1'b0, RBS_ADDR_PM, 32'h0000_000a);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
    endtask : do_boot

    initial
    begin
        {sys_rst, rst_req, boot_req, ratio_req} = 6'h30;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {data_pin_in, mem_data_out, flag_out, flag_oe, mem_data_oe} = '0;
        {m_pm, m_sys, m_ovr, p_sel, p_run, p_mode} = '0;
        {mismatches, checked, cnt, waslow} = {32'h0, 32'h0, 32'h0, 1'b1};
        void'($urandom(72));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int c = 0; c < 4; c++)
            do_boot(2'(c));
        // Every data pin mode under random traffic
        for (int m = 0; m < 8; m++)
        begin
            bus(1'b1, 1'b0, RBS_ADDR_SYS, 32'(m));
            repeat (6)
            begin
                rnd_in();
                bus(1'b0, 1'b0, 8'h00, 32'h0);
            end
        end
        bus(1'b1, 1'b0, 8'h0c, 32'hffff_ffff);
        bus(1'b0, 1'b1, 8'h0c, 32'h0);
        bus(1'b0, 1'b1, RBS_ADDR_SYS, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        do_boot(2'h2);
        wrap_up();
    end
endmodule : tb_top
